// File: pkg/odrcr_pkg.sv
// Shared constants and types for the text overlay display memory and renderer
package odrcr_pkg;

    // ------------------------------------------------------------
    // Display memory geometry
    // ------------------------------------------------------------
    localparam int unsigned RAM_DEPTH = 128;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned CODE_W = 6;
    localparam int unsigned ATTR_W = 4;
    localparam int unsigned WORD_W = 10;
    localparam logic [ADDR_W-1:0] ROW_ORIGIN = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 7'h01;

    // ------------------------------------------------------------
    // Register select codes
    // ------------------------------------------------------------
    localparam logic [7:0] SFR_CHAR_ATTRIBUTES = 8'hC1;
    localparam logic [7:0] SFR_CHAR_CODE = 8'hC2;
    localparam logic [7:0] SFR_WRITE_ADDRESS = 8'hC3;
    localparam int unsigned SFR_ATTR_HI_BIT = 4;
    localparam int unsigned SFR_ADDR_TOP_BIT = 7;

    // ------------------------------------------------------------
    // Character codes and stored attribute fields
    // ------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_SPACE = 6'h3C;
    localparam logic [CODE_W-1:0] CODE_NEWLINE = 6'h3D;
    localparam logic [CODE_W-1:0] CODE_COLOUR_SPACE = 6'h3E;
    localparam logic [CODE_W-1:0] CODE_HALF_COLOUR_SPACE = 6'h3F;
    localparam int unsigned A_FILL = 3;
    localparam int unsigned A_END = 3;
    localparam int unsigned A_THIN = 2;
    localparam int unsigned A_DOUBLE = 1;
    localparam int unsigned A_UMBRA = 0;
    localparam int unsigned A_COLOUR_HI = 2;
    localparam logic [2:0] BLACK = 3'h0;

    // ------------------------------------------------------------
    // Glyph and row timing
    // ------------------------------------------------------------
    localparam int unsigned GLYPH_DOTS = 14;
    localparam logic [3:0] GLYPH_LAST_COL = 4'hD;
    localparam logic [4:0] GLYPH_TOP = 5'h00;
    localparam logic [4:0] GLYPH_BOTTOM = 5'h11;
    localparam logic [5:0] ROW_LINES = 6'h12;
    localparam logic [5:0] ROW_LINES_DBL = 6'h24;
    localparam logic [5:0] THIN_LINES = 6'h04;
    localparam logic [5:0] THIN_LINES_DBL = 6'h08;
    localparam logic [4:0] CHAR_DOTS = 5'h0E;
    localparam logic [4:0] CHAR_DOTS_DBL = 5'h1C;
    localparam logic [4:0] HALF_DOTS = 5'h07;
    localparam logic [4:0] HALF_DOTS_DBL = 5'h0E;
    localparam logic [7:0] HSTART_DOTS = 8'h11;
    localparam logic [5:0] VSTART_LINES = 6'h03;

    // ------------------------------------------------------------
    // Modes and horizontal states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_INTERNAL = 2'b01,
        MODE_NORMAL = 2'b10,
        MODE_SOLID = 2'b11
    } odrcr_mode_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LEAD = 2'b01,
        H_CHARS = 2'b10,
        H_HALT = 2'b11
    } odrcr_hstate_t;

endpackage : odrcr_pkg

// File: core/odrcr_display_ram.sv
// Dual-ported flip-flop display memory
`timescale 1ns/1ps
module odrcr_display_ram (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [odrcr_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [odrcr_pkg::WORD_W-1:0] wr_data_i,
    input wire logic [odrcr_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [odrcr_pkg::WORD_W-1:0] rd_data_o
);
    import odrcr_pkg::*;

    logic [WORD_W-1:0] mem_reg [RAM_DEPTH];

    // ------------------------------------------------------------
    // Write port, one entry per location
    // ------------------------------------------------------------
    for (genvar gi = 0; gi < RAM_DEPTH; gi++) begin : g_entry
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                mem_reg[gi] <= '0;
            end else if (wr_en_i && (wr_addr_i == ADDR_W'(gi))) begin
                mem_reg[gi] <= wr_data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Independent fetch port
    // ------------------------------------------------------------
    assign rd_data_o = mem_reg[rd_addr_i];

endmodule : odrcr_display_ram

// File: core/odrcr_top.sv
// Text overlay: register port, display memory and character renderer
`timescale 1ns/1ps
module odrcr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic [1:0] overlay_mode_register_i,
    input wire logic hsync_i,
    input wire logic vsync_i,
    input wire logic video_dot_clock_i,
    output logic video_osc_pin_two_o,
    output logic video_osc_pin_two_oe_o,
    output logic [2:0] colour_video_outputs_o,
    output logic overlay_select_output_o
);
    import odrcr_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] hs_pipe_reg;
    logic [2:0] vs_pipe_reg;
    logic [2:0] vck_pipe_reg;
    logic hs_level;
    logic vs_level;
    logic hs_lead;
    logic hs_trail;
    logic vs_lead;
    logic dot_en;
    odrcr_mode_t mode;
    logic run;
    logic solid;
    logic blank;
    logic osc_hold_reg;
    logic pin_low_reg;

    logic [7:0] addr_reg;
    logic [7:0] attr_reg;
    logic [7:0] rdata_reg;
    logic wr_addr;
    logic wr_attr;
    logic wr_code;
    logic [WORD_W-1:0] wr_word;
    logic [WORD_W-1:0] word;
    logic [CODE_W-1:0] code;
    logic [ATTR_W-1:0] ch_attr;
    logic is_newline;

    logic [ADDR_W-1:0] row_start_reg;
    logic [ADDR_W-1:0] ptr_reg;
    logic end_reg;
    logic double_reg;
    logic umbra_reg;
    logic thin_reg;
    logic in_rows_reg;
    logic [5:0] vline_reg;
    logic [5:0] line_reg;
    logic [7:0] hcnt_reg;
    logic [4:0] dot_reg;
    odrcr_hstate_t hstate_reg;
    logic [2:0] bg_colour_reg;
    logic bg_fill_reg;
    logic prev_bit_reg;
    logic [2:0] colour_reg;
    logic overlay_reg;

    logic [5:0] row_lines;
    logic [4:0] char_dots;
    logic [4:0] half_dots;
    logic [3:0] glyph_col;
    logic [4:0] glyph_line;
    logic [GLYPH_DOTS-1:0] glyph_row;
    logic pix_bit;
    logic shadow_bit;
    logic in_chars;

    // ------------------------------------------------------------
    // Stand-in glyph set, one row of dots per line
    // ------------------------------------------------------------
    function automatic logic [GLYPH_DOTS-1:0] glyph(input logic [CODE_W-1:0] c, input logic [4:0] line);
        logic [GLYPH_DOTS-1:0] row;
        row = '0;
        if ((c < CODE_SPACE) && (line > GLYPH_TOP) && (line < GLYPH_BOTTOM)) begin
            row = {1'b0, c, c, 1'b0};
        end
        return row;
    endfunction : glyph

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hs_pipe_reg <= '0;
            vs_pipe_reg <= '0;
            vck_pipe_reg <= '0;
        end else begin
            hs_pipe_reg <= {hs_pipe_reg[1:0], hsync_i};
            vs_pipe_reg <= {vs_pipe_reg[1:0], vsync_i};
            vck_pipe_reg <= {vck_pipe_reg[1:0], video_dot_clock_i};
        end
    end

    assign hs_level = hs_pipe_reg[1];
    assign vs_level = vs_pipe_reg[1];
    assign hs_lead = hs_pipe_reg[1] & ~hs_pipe_reg[2];
    assign hs_trail = ~hs_pipe_reg[1] & hs_pipe_reg[2];
    assign vs_lead = vs_pipe_reg[1] & ~vs_pipe_reg[2];
    assign dot_en = vck_pipe_reg[1] & ~vck_pipe_reg[2];

    assign mode = odrcr_mode_t'(overlay_mode_register_i);
    assign run = (mode != MODE_OFF);
    assign solid = (mode == MODE_SOLID);
    assign blank = hs_level | vs_level | (mode == MODE_OFF) | (mode == MODE_INTERNAL);

    // ------------------------------------------------------------
    // Dot oscillator hold
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_hold_reg <= 1'b1;
        end else begin
            osc_hold_reg <= hs_level | ~run;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_low_reg <= 1'b0;
        end else begin
            pin_low_reg <= 1'b0;
        end
    end

    assign video_osc_pin_two_o = pin_low_reg;
    assign video_osc_pin_two_oe_o = osc_hold_reg;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    assign wr_addr = sfr_wr_i && (sfr_addr_i == SFR_WRITE_ADDRESS);
    assign wr_attr = sfr_wr_i && (sfr_addr_i == SFR_CHAR_ATTRIBUTES);
    assign wr_code = sfr_wr_i && (sfr_addr_i == SFR_CHAR_CODE);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_reg <= '0;
        end else if (wr_addr) begin
            addr_reg <= sfr_wdata_i;
        end else if (wr_code) begin
            addr_reg <= {addr_reg[SFR_ADDR_TOP_BIT], addr_reg[ADDR_W-1:0] + ADDR_STEP};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            attr_reg <= '0;
        end else if (wr_attr) begin
            attr_reg <= sfr_wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                SFR_WRITE_ADDRESS: rdata_reg <= addr_reg;
                SFR_CHAR_ATTRIBUTES: rdata_reg <= attr_reg;
                default: rdata_reg <= '0;
            endcase
        end
    end

    assign sfr_rdata_o = rdata_reg;

    assign wr_word = {attr_reg[SFR_ATTR_HI_BIT], attr_reg[A_COLOUR_HI:0], sfr_wdata_i[CODE_W-1:0]};

    odrcr_display_ram u_ram (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(wr_code),
        .wr_addr_i(addr_reg[ADDR_W-1:0]),
        .wr_data_i(wr_word),
        .rd_addr_i(ptr_reg),
        .rd_data_o(word)
    );

    // ------------------------------------------------------------
    // Fetch decode and glyph lookup
    // ------------------------------------------------------------
    assign code = word[CODE_W-1:0];
    assign ch_attr = word[WORD_W-1:CODE_W];
    assign is_newline = (code == CODE_NEWLINE);
    assign in_chars = (hstate_reg == H_CHARS);

    assign row_lines = thin_reg ? (double_reg ? THIN_LINES_DBL : THIN_LINES)
                                : (double_reg ? ROW_LINES_DBL : ROW_LINES);
    assign char_dots = double_reg ? CHAR_DOTS_DBL : CHAR_DOTS;
    assign half_dots = double_reg ? HALF_DOTS_DBL : HALF_DOTS;
    assign glyph_col = double_reg ? dot_reg[4:1] : dot_reg[3:0];
    assign glyph_line = double_reg ? line_reg[5:1] : line_reg[4:0];
    assign glyph_row = glyph(code, glyph_line);
    assign pix_bit = in_chars & ~is_newline & glyph_row[GLYPH_LAST_COL - glyph_col];
    assign shadow_bit = umbra_reg & in_chars & ~pix_bit & prev_bit_reg;

    // ------------------------------------------------------------
    // Vertical position and row attributes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            row_start_reg <= ROW_ORIGIN;
            end_reg <= 1'b0;
            double_reg <= 1'b0;
            umbra_reg <= 1'b0;
            thin_reg <= 1'b0;
            in_rows_reg <= 1'b0;
            vline_reg <= '0;
            line_reg <= '0;
        end else if (vs_lead) begin
            row_start_reg <= ROW_ORIGIN;
            end_reg <= 1'b0;
            double_reg <= 1'b0;
            umbra_reg <= 1'b0;
            thin_reg <= 1'b0;
            in_rows_reg <= 1'b0;
            vline_reg <= '0;
            line_reg <= '0;
        end else if (hs_lead && run) begin
            if (!in_rows_reg) begin
                if (vline_reg == VSTART_LINES) begin
                    in_rows_reg <= 1'b1;
                end else begin
                    vline_reg <= vline_reg + 6'h01;
                end
            end else if (!end_reg) begin
                if (line_reg == (row_lines - 6'h01)) begin
                    line_reg <= '0;
                    if (hstate_reg == H_HALT) begin
                        row_start_reg <= ptr_reg + ADDR_STEP;
                        end_reg <= ch_attr[A_END];
                        double_reg <= ~ch_attr[A_END] & ch_attr[A_DOUBLE];
                        umbra_reg <= ~ch_attr[A_END] & ch_attr[A_UMBRA];
                        thin_reg <= ~ch_attr[A_END] & ch_attr[A_THIN];
                    end else begin
                        row_start_reg <= ptr_reg;
                        double_reg <= 1'b0;
                        umbra_reg <= 1'b0;
                        thin_reg <= 1'b0;
                    end
                end else begin
                    line_reg <= line_reg + 6'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Horizontal sequencing of characters
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hstate_reg <= H_IDLE;
            hcnt_reg <= '0;
            ptr_reg <= ROW_ORIGIN;
            dot_reg <= '0;
            prev_bit_reg <= 1'b0;
        end else if (hs_trail) begin
            hstate_reg <= H_LEAD;
            hcnt_reg <= '0;
            ptr_reg <= row_start_reg;
            dot_reg <= '0;
            prev_bit_reg <= 1'b0;
        end else if (dot_en && run) begin
            case (hstate_reg)
                H_LEAD: begin
                    if (hcnt_reg == HSTART_DOTS) begin
                        hstate_reg <= (in_rows_reg && !end_reg) ? H_CHARS : H_IDLE;
                    end else begin
                        hcnt_reg <= hcnt_reg + 8'h01;
                    end
                end
                H_CHARS: begin
                    if (is_newline) begin
                        hstate_reg <= H_HALT;
                    end else begin
                        prev_bit_reg <= pix_bit;
                        if (dot_reg == (char_dots - 5'h01)) begin
                            dot_reg <= '0;
                            ptr_reg <= ptr_reg + ADDR_STEP;
                        end else begin
                            dot_reg <= dot_reg + 5'h01;
                        end
                    end
                end
                H_IDLE: begin
                    hstate_reg <= H_IDLE;
                end
                H_HALT: begin
                    hstate_reg <= H_HALT;
                end
                default: begin
                    hstate_reg <= H_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Background colour state
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bg_colour_reg <= BLACK;
            bg_fill_reg <= 1'b0;
        end else if (dot_en && run && in_chars) begin
            if (((code == CODE_COLOUR_SPACE) && (dot_reg == '0)) ||
                ((code == CODE_HALF_COLOUR_SPACE) && (dot_reg == half_dots))) begin
                bg_colour_reg <= ch_attr[A_COLOUR_HI:0];
                bg_fill_reg <= ch_attr[A_FILL];
            end
        end
    end

    // ------------------------------------------------------------
    // Pixel outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            colour_reg <= BLACK;
            overlay_reg <= 1'b0;
        end else if (blank) begin
            colour_reg <= BLACK;
            overlay_reg <= 1'b0;
        end else if (dot_en) begin
            if (in_chars && !is_newline) begin
                if (pix_bit) begin
                    colour_reg <= ch_attr[A_COLOUR_HI:0];
                    overlay_reg <= 1'b1;
                end else if (shadow_bit) begin
                    colour_reg <= BLACK;
                    overlay_reg <= 1'b1;
                end else begin
                    colour_reg <= bg_colour_reg;
                    overlay_reg <= ch_attr[A_FILL] | solid;
                end
            end else begin
                colour_reg <= bg_colour_reg;
                overlay_reg <= solid & (in_chars | (hstate_reg == H_HALT));
            end
        end
    end

    assign colour_video_outputs_o = colour_reg;
    assign overlay_select_output_o = overlay_reg;

endmodule : odrcr_top

// File: testbench/odrcr_top_chk.sv
// Port-level assertions for the text overlay top
`timescale 1ns/1ps
module odrcr_top_chk
    import odrcr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [1:0] overlay_mode_register_i,
    input wire logic hsync_i,
    input wire logic vsync_i,
    input wire logic video_dot_clock_i,
    input wire logic video_osc_pin_two_o,
    input wire logic video_osc_pin_two_oe_o,
    input wire logic [2:0] colour_video_outputs_o,
    input wire logic overlay_select_output_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] addr_m_reg;
    logic [7:0] attr_m_reg;
    logic blank;
    assign blank = (colour_video_outputs_o == BLACK) && !overlay_select_output_o;
    // ------------------------------------------------------------
    // Register mirrors
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_m_reg <= 8'h00;
        end else if (sfr_wr_i && sfr_addr_i == SFR_WRITE_ADDRESS) begin
            addr_m_reg <= sfr_wdata_i;
        end else if (sfr_wr_i && sfr_addr_i == SFR_CHAR_CODE) begin
            addr_m_reg <= {addr_m_reg[7], addr_m_reg[6:0] + 7'h01};
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            attr_m_reg <= 8'h00;
        end else if (sfr_wr_i && sfr_addr_i == SFR_CHAR_ATTRIBUTES) begin
            attr_m_reg <= sfr_wdata_i;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_addr_read_back: assert property (sfr_rd_i && sfr_addr_i == SFR_WRITE_ADDRESS |=>
        sfr_rdata_o == $past(addr_m_reg)) else $error("address readback wrong");
    chk_attr_read_back: assert property (sfr_rd_i && sfr_addr_i == SFR_CHAR_ATTRIBUTES |=>
        (sfr_rdata_o & 8'h17) == ($past(attr_m_reg) & 8'h17)) else $error("attribute readback wrong");
    chk_code_unread: assert property (sfr_rd_i && sfr_addr_i == SFR_CHAR_CODE |=>
        sfr_rdata_o == 8'h00) else $error("char code readable");
    chk_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without read");
    chk_hsync_blank: assert property (hsync_i [*5] |-> blank) else $error("not blank in hsync");
    chk_vsync_blank: assert property (vsync_i [*5] |-> blank) else $error("not blank in vsync");
    chk_mode_blank: assert property ((overlay_mode_register_i < 2'b10) [*2] |-> blank)
        else $error("not blank in low mode");
    chk_osc_hold: assert property (hsync_i [*5] |-> video_osc_pin_two_oe_o && !video_osc_pin_two_o)
        else $error("oscillator not held");
    chk_osc_run: assert property ((!hsync_i && overlay_mode_register_i != 2'b00) [*5]
        |-> !video_osc_pin_two_oe_o) else $error("oscillator not released");
    chk_off_hold: assert property ((overlay_mode_register_i == 2'b00) [*2] |-> video_osc_pin_two_oe_o)
        else $error("oscillator running in off mode");
    cover property (sfr_wr_i && sfr_addr_i == SFR_CHAR_CODE);
    cover property (overlay_select_output_o && colour_video_outputs_o != BLACK);
    cover property (!blank ##1 hsync_i);
endmodule : odrcr_top_chk

bind odrcr_top odrcr_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .overlay_mode_register_i(overlay_mode_register_i), .hsync_i(hsync_i), .vsync_i(vsync_i),
    .video_dot_clock_i(video_dot_clock_i), .video_osc_pin_two_o(video_osc_pin_two_o),
    .video_osc_pin_two_oe_o(video_osc_pin_two_oe_o), .colour_video_outputs_o(colour_video_outputs_o),
    .overlay_select_output_o(overlay_select_output_o));

// File: testbench/odrcr_video_src.sv
// Behavioural TV sync source and held dot oscillator
`timescale 1ns/1ps
module odrcr_video_src #(parameter int LINES = 24, parameter int DOTS = 64) (
    input wire logic run_i,
    input wire logic osc_hold_i,
    output logic hsync_o,
    output logic vsync_o,
    output logic dot_clock_o
);
    initial begin
        hsync_o = 1'b0;
        vsync_o = 1'b0;
        dot_clock_o = 1'b0;
    end
    always begin
        wait (run_i);
        vsync_o = 1'b1;
        #4000;
        vsync_o = 1'b0;
        repeat (LINES) begin
            hsync_o = 1'b1;
            #3000;
            hsync_o = 1'b0;
            repeat (DOTS) begin
                #100;
                dot_clock_o = !osc_hold_i;
                #100;
                dot_clock_o = 1'b0;
            end
        end
    end
endmodule : odrcr_video_src

// File: testbench/odrcr_test.sv
// Self-checking bench for the text overlay top
`timescale 1ns/1ps
module odrcr_test;
    import odrcr_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, run = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
    logic [1:0] mode = 2'b00;
    logic hsync, vsync, dot_clk, pin_two, pin_two_oe, overlay;
    logic [2:0] colour;
    int mismatches = 0, compares = 0, bg_hits = 0, fg_hits = 0, sh_hits = 0, so_hits = 0;
    always #12.5 clk_i = ~clk_i;
    always @(negedge clk_i) begin
        if (colour == 3'h5) bg_hits++;
        if (colour == 3'h3 && overlay) fg_hits++;
        if (colour == 3'h0 && overlay) sh_hits++;
        if (colour == 3'h5 && overlay) so_hits++;
    end
    odrcr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .overlay_mode_register_i(mode), .hsync_i(hsync), .vsync_i(vsync), .video_dot_clock_i(dot_clk),
        .video_osc_pin_two_o(pin_two), .video_osc_pin_two_oe_o(pin_two_oe),
        .colour_video_outputs_o(colour), .overlay_select_output_o(overlay));
    odrcr_video_src u_src (.run_i(run), .osc_hold_i(pin_two_oe), .hsync_o(hsync), .vsync_o(vsync),
        .dot_clock_o(dot_clk));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge clk_i);
        sfr_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge clk_i);
        sfr_rd_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check(name, sfr_rdata_o, exp);
    endtask : rd
    task automatic field;
        @(negedge vsync);
        bg_hits = 0;
        fg_hits = 0;
        sh_hits = 0;
        so_hits = 0;
        @(posedge vsync);
    endtask : field
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        #2400000;
        mismatches++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check("reset outputs", {pin_two_oe, pin_two, overlay, 2'b00, colour}, 8'h80);
        check("reset rdata", sfr_rdata_o, 8'h00);
        wr(SFR_WRITE_ADDRESS, 8'h7F);
        wr(SFR_CHAR_CODE, {2'b00, CODE_SPACE});
        rd("wrap address", SFR_WRITE_ADDRESS, 8'h00);
        wr(SFR_WRITE_ADDRESS, 8'h85);
        wr(SFR_CHAR_ATTRIBUTES, 8'h13);
        wr(SFR_CHAR_CODE, {2'b00, CODE_SPACE});
        rd("step address", SFR_WRITE_ADDRESS, 8'h86);
        rd("attributes", SFR_CHAR_ATTRIBUTES, 8'h13);
        rd("code read", SFR_CHAR_CODE, 8'h00);
        rd("unmapped read", 8'hA5, 8'h00);
        wr(SFR_WRITE_ADDRESS, 8'h00);
        wr(SFR_CHAR_ATTRIBUTES, 8'h15);
        wr(SFR_CHAR_CODE, {2'b00, CODE_COLOUR_SPACE});
        wr(SFR_CHAR_ATTRIBUTES, 8'h03);
        wr(SFR_CHAR_CODE, 8'h0A);
        wr(SFR_CHAR_CODE, 8'h0A);
        wr(SFR_CHAR_ATTRIBUTES, 8'h10);
        wr(SFR_CHAR_CODE, {2'b00, CODE_NEWLINE});
        rd("fill address", SFR_WRITE_ADDRESS, 8'h04);
        @(posedge clk_i);
        mode <= MODE_INTERNAL;
        run <= 1'b1;
        field;
        check("blanked hits", 8'((bg_hits + fg_hits + sh_hits + so_hits) != 0), 8'h00);
        wr(SFR_WRITE_ADDRESS, 8'h00);
        wr(SFR_CHAR_ATTRIBUTES, 8'h00);
        wr(SFR_CHAR_CODE, {2'b00, CODE_SPACE});
        mode <= MODE_NORMAL;
        field;
        check("kept background", 8'(bg_hits != 0), 8'h01);
        check("foreground", 8'(fg_hits != 0), 8'h01);
        check("plain fill", 8'(so_hits != 0), 8'h00);
        check("no umbra", 8'(sh_hits != 0), 8'h00);
        wr(SFR_WRITE_ADDRESS, 8'h00);
        wr(SFR_CHAR_ATTRIBUTES, 8'h01);
        wr(SFR_CHAR_CODE, {2'b00, CODE_NEWLINE});
        mode <= MODE_SOLID;
        field;
        check("umbra", 8'(sh_hits != 0), 8'h01);
        check("solid fill", 8'(so_hits != 0), 8'h01);
        @(posedge clk_i);
        mode <= MODE_OFF;
        repeat (20) @(posedge clk_i);
        #1;
        check("off outputs", {pin_two_oe, pin_two, overlay, 2'b00, colour}, 8'h80);
        complete_run;
    end
endmodule : odrcr_test
